// >>> core/cps_defines.vh
// constants for the pointer, string and status register block
`ifndef CPS_DEFINES_VH
`define CPS_DEFINES_VH
`define CPS_DATA_W 16
`define CPS_STAT_W 17
`define CPS_REG_LOOP 3'h4
`define CPS_REG_INDEX 3'h5
`define CPS_REG_PAGE 3'h6
`define CPS_REG_STACK 3'h7
`define CPS_STACK_STEP 16'h0002
`define CPS_STR_OFFSET 6'h02
`define CPS_STR_MAX 5'h1E
`define CPS_STR_RESET 5'h00
`define CPS_STAT_RESET 17'h00000
`define CPS_MODE_COUNT 5
`define CPS_BIT_XM 0
`define CPS_BIT_UM 1
`define CPS_BIT_OM 2
`define CPS_BIT_FM 3
`define CPS_BIT_IM 4
`define CPS_BIT_RSV 5
`define CPS_BIT_XZF 6
`define CPS_BIT_XSF 7
`define CPS_BIT_RCF 8
`define CPS_BIT_RZF 9
`define CPS_BIT_OF 10
`define CPS_BIT_SF 11
`define CPS_BIT_ZF 12
`define CPS_BIT_CF 13
`define CPS_BIT_TF1 14
`define CPS_BIT_TF2 15
`define CPS_BIT_TAG 16
`define CPS_DST_NONE 2'h0
`define CPS_DST_ACC 2'h1
`define CPS_DST_PTR 2'h2
`define CPS_DST_BUS 2'h3
`endif

// >>> core/cps_flag_calc.v
// flag calculation for a transfer result
`timescale 1ns/1ps
module cps_flag_calc (
  input wire [15:0] value,
  output wire is_zero,
  output wire is_neg
);
  assign is_zero = (value == 16'h0000);
  assign is_neg = value[15];
endmodule

// >>> core/cps_core_regs.v
// indirect registers, string length register and status word
//
// Overview of operation
// - eight 16-bit indirect registers, general storage and address sources
// - loop counter n in 0..32767 runs the loop body n+2 times
// - hardware loop ends once the loop counter goes negative
// - register 5 supplies the index operand for indexed addressing
// - register 6 supplies the page base for page-relative addressing
// - call adds 2 to stack pointer, return subtracts 2
// - chain length value n means n+2 words, n legal 0..30
// - string instructions leave the chain length register unchanged
// - 17-bit status word, five mode bits low, flags in upper eleven
// - mode bits xm, um, om, fm, interrupt enable at bits 0..4
// - destination kind selects accumulator, pointer or transfer flags
// - sign flag bit 11 follows accumulator msb
// - zero flag bit 12 set when accumulator result is zero
// - carry flag bit 13 follows alu carry out
// - overflow flag bit 10 follows accumulator overflow
// - pointer carry bit 8 on add carry, pointer zero bit 9
// - transfer destination sets bit 6 on zero, bit 7 from sign; no destination touches no destination flags, but pointer use still sets bit 9
// - bits 14 and 15 test flags, bit 5 reserved
// - bit 16 captures memory tag bit on every memory read
`include "cps_defines.vh"
`timescale 1ns/1ps
module cps_core_regs (
  input wire clock,
  input wire rst_n,
  input wire reg_wr_en,
  input wire [2:0] reg_wr_sel,
  input wire [15:0] reg_wr_data,
  input wire [2:0] reg_rd_sel,
  output reg [15:0] reg_rd_data,
  input wire ptr_add_en,
  input wire [2:0] ptr_add_sel,
  input wire [15:0] ptr_add_value,
  input wire [2:0] ptr_use_sel,
  input wire ptr_use_en,
  output reg [15:0] index_value,
  output reg [15:0] page_base_value,
  input wire loop_end_instr,
  output wire loop_taken,
  input wire call_instr,
  input wire return_instr,
  output reg [15:0] stack_pointer_value,
  input wire chain_wr_en,
  input wire [4:0] chain_wr_data,
  output reg [4:0] chain_length_reg,
  output wire [5:0] string_words,
  output wire chain_illegal,
  input wire stat_wr_en,
  input wire [16:0] stat_wr_data,
  input wire mode_set_en,
  input wire mode_clr_en,
  input wire [2:0] mode_sel,
  input wire [1:0] dst_kind,
  input wire [15:0] dst_value,
  input wire alu_flags_en,
  input wire alu_carry,
  input wire alu_overflow,
  input wire test_wr_en,
  input wire [1:0] test_wr_data,
  input wire mem_rd_en,
  input wire mem_tag_bit,
  output reg [16:0] condition_mode_word,
  output wire sign_extend_mode,
  output wire unsigned_multiply_mode,
  output wire saturation_mode,
  output wire fraction_shift_mode,
  output wire interrupt_enable_bit
);
  // ==========================================================
  // storage
  reg [15:0] pointer_file [0:7];
  reg [15:0] next_ptr [0:7];
  reg [16:0] next_stat;
  reg [4:0] next_chain;
  reg [16:0] add_sum;
  wire [15:0] loop_dec;
  wire dst_zero;
  wire dst_neg;
  wire ptr_used_zero;
  wire [15:0] loop_counter_reg;
  wire [15:0] stack_pointer_reg;
  integer i;

  cps_flag_calc u_flag (
    .value(dst_value),
    .is_zero(dst_zero),
    .is_neg(dst_neg)
  );

  // ==========================================================
  // helper functions
  // stack moves two words per call or return
  function [15:0] step_stack;
    input [15:0] sp;
    input up;
    begin
      if (up) begin
        step_stack = sp + `CPS_STACK_STEP;
      end else begin
        step_stack = sp - `CPS_STACK_STEP;
      end
    end
  endfunction

  // mode select inside the five mode bits
  function mode_sel_ok;
    input [2:0] sel;
    begin
      mode_sel_ok = (sel < `CPS_MODE_COUNT);
    end
  endfunction

  // zero test of a pointer word
  function is_zero16;
    input [15:0] word;
    begin
      is_zero16 = (word == 16'h0000);
    end
  endfunction

  // ==========================================================
  // role names of the pointer file
  assign loop_counter_reg = pointer_file[`CPS_REG_LOOP];
  assign stack_pointer_reg = pointer_file[`CPS_REG_STACK];
  assign ptr_used_zero = is_zero16(pointer_file[ptr_use_sel]);

  // ==========================================================
  // hardware loop, branch back while the count before decrement is non-negative
  assign loop_dec = loop_counter_reg - 16'h0001;
  assign loop_taken = loop_end_instr & ~loop_counter_reg[15];

  // ==========================================================
  // string length
  assign string_words = {1'b0, chain_length_reg} + `CPS_STR_OFFSET;
  assign chain_illegal = (chain_length_reg > `CPS_STR_MAX);

  // ==========================================================
  // mode outputs

  assign sign_extend_mode = condition_mode_word[`CPS_BIT_XM];
  assign unsigned_multiply_mode = condition_mode_word[`CPS_BIT_UM];
  assign saturation_mode = condition_mode_word[`CPS_BIT_OM];
  assign fraction_shift_mode = condition_mode_word[`CPS_BIT_FM];
  assign interrupt_enable_bit = condition_mode_word[`CPS_BIT_IM];

  // ==========================================================
  // next state of pointer file
  always @* begin
    for (i = 0; i < 8; i = i + 1) begin
      next_ptr[i] = pointer_file[i];
    end
    add_sum = {1'b0, pointer_file[ptr_add_sel]} + {1'b0, ptr_add_value};
    if (ptr_add_en) begin
      next_ptr[ptr_add_sel] = add_sum[15:0];
    end
    if (loop_end_instr) begin
      next_ptr[`CPS_REG_LOOP] = loop_dec;
    end
    if (call_instr) begin
      next_ptr[`CPS_REG_STACK] = step_stack(stack_pointer_reg, 1'b1);
    end else if (return_instr) begin
      next_ptr[`CPS_REG_STACK] = step_stack(stack_pointer_reg, 1'b0);
    end
    if (reg_wr_en) begin
      next_ptr[reg_wr_sel] = reg_wr_data;
    end
  end

  // ==========================================================
  // next state of status word
  always @* begin
    next_stat = condition_mode_word;
    if (stat_wr_en) begin
      next_stat = stat_wr_data;
    end
    if (mode_set_en && mode_sel_ok(mode_sel)) begin
      next_stat[mode_sel] = 1'b1;
    end else if (mode_clr_en && mode_sel_ok(mode_sel)) begin
      next_stat[mode_sel] = 1'b0;
    end
    // flag updates follow the move so they win
    case (dst_kind)
      `CPS_DST_ACC: begin
        next_stat[`CPS_BIT_SF] = dst_neg;
        next_stat[`CPS_BIT_ZF] = dst_zero;
        if (alu_flags_en) begin
          next_stat[`CPS_BIT_CF] = alu_carry;
          next_stat[`CPS_BIT_OF] = alu_overflow;
        end
      end
      `CPS_DST_PTR: begin
        next_stat[`CPS_BIT_RZF] = dst_zero;
        if (ptr_add_en) begin
          next_stat[`CPS_BIT_RCF] = add_sum[16];
        end
      end
      `CPS_DST_BUS: begin
        next_stat[`CPS_BIT_XZF] = dst_zero;
        next_stat[`CPS_BIT_XSF] = dst_neg;
      end
      default: begin
        // no destination flags touched
      end
    endcase
    if (ptr_use_en && dst_kind != `CPS_DST_PTR) begin
      next_stat[`CPS_BIT_RZF] = ptr_used_zero;
    end
    if (test_wr_en) begin
      next_stat[`CPS_BIT_TF2:`CPS_BIT_TF1] = test_wr_data;
    end
    if (mem_rd_en) begin
      next_stat[`CPS_BIT_TAG] = mem_tag_bit;
    end
    next_stat[`CPS_BIT_RSV] = 1'b0;
  end

  // ==========================================================
  // chain length register, untouched by string execution
  always @* begin
    next_chain = chain_length_reg;
    if (chain_wr_en) begin
      next_chain = chain_wr_data;
    end
  end

  // ==========================================================
  // pointer file register
  always @(posedge clock) begin
    if (!rst_n) begin
      for (i = 0; i < 8; i = i + 1) begin
        pointer_file[i] <= 16'h0000;
      end
    end else begin
      for (i = 0; i < 8; i = i + 1) begin
        pointer_file[i] <= next_ptr[i];
      end
    end
  end

  // ==========================================================
  // status word register
  always @(posedge clock) begin
    if (!rst_n) begin
      condition_mode_word <= `CPS_STAT_RESET;
    end else begin
      condition_mode_word <= next_stat;
    end
  end

  // ==========================================================
  // chain length register
  always @(posedge clock) begin
    if (!rst_n) begin
      chain_length_reg <= `CPS_STR_RESET;
    end else begin
      chain_length_reg <= next_chain;
    end
  end

  // ==========================================================
  // registered read port, shows the file after this edge
  always @(posedge clock) begin
    if (!rst_n) begin
      reg_rd_data <= 16'h0000;
    end else begin
      reg_rd_data <= next_ptr[reg_rd_sel];
    end
  end

  // ==========================================================
  // index operand
  always @(posedge clock) begin
    if (!rst_n) begin
      index_value <= 16'h0000;
    end else begin
      index_value <= next_ptr[`CPS_REG_INDEX];
    end
  end

  // ==========================================================
  // page base
  always @(posedge clock) begin
    if (!rst_n) begin
      page_base_value <= 16'h0000;
    end else begin
      page_base_value <= next_ptr[`CPS_REG_PAGE];
    end
  end

  // ==========================================================
  // stack pointer
  always @(posedge clock) begin
    if (!rst_n) begin
      stack_pointer_value <= 16'h0000;
    end else begin
      stack_pointer_value <= next_ptr[`CPS_REG_STACK];
    end
  end
endmodule

// >>> bench/cps_regs_monitor.sv
// checker on the ports of the core register block
`timescale 1ns/1ps
module cps_regs_monitor (
  input wire clock,
  input wire rst_n,
  input wire reg_wr_en,
  input wire call_instr,
  input wire chain_wr_en,
  input wire stat_wr_en,
  input wire mode_set_en,
  input wire mem_rd_en,
  input wire mem_tag_bit,
  input wire [2:0] reg_wr_sel,
  input wire [2:0] mode_sel,
  input wire [15:0] stack_pointer_value,
  input wire [15:0] dst_value,
  input wire [4:0] chain_length_reg,
  input wire [5:0] string_words,
  input wire [1:0] dst_kind,
  input wire [16:0] condition_mode_word
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_sp; call_instr && !(reg_wr_en && reg_wr_sel == 3'h7) |=>
    stack_pointer_value == $past(stack_pointer_value) + 16'h0002; endproperty
  a_sp: assert property (p_sp) else $error("stack step wrong");
  property p_len; string_words == {1'b0, chain_length_reg} + 6'h02; endproperty
  a_len: assert property (p_len) else $error("string length wrong");
  property p_hold; !chain_wr_en |=> $stable(chain_length_reg); endproperty
  a_hold: assert property (p_hold) else $error("chain length moved");
  property p_mode; mode_set_en && mode_sel < 3'h5 && !stat_wr_en |=> condition_mode_word[$past(mode_sel)]; endproperty
  a_mode: assert property (p_mode) else $error("mode bit not set");
  property p_rsv; condition_mode_word[5] == 1'b0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_acc; dst_kind == 2'h1 |=>
    condition_mode_word[12:11] == {$past(dst_value) == 16'h0000, $past(dst_value[15])}; endproperty
  a_acc: assert property (p_acc) else $error("acc flags wrong");
  property p_bus; dst_kind == 2'h3 |=>
    condition_mode_word[7:6] == {$past(dst_value[15]), $past(dst_value) == 16'h0000}; endproperty
  a_bus: assert property (p_bus) else $error("transfer flags wrong");
  property p_tag; mem_rd_en |=> condition_mode_word[16] == $past(mem_tag_bit); endproperty
  a_tag: assert property (p_tag) else $error("tag bit wrong");
endmodule
bind cps_core_regs cps_regs_monitor u_mon (.*);

// >>> bench/tb_cps_core_regs.sv
// self-checking bench for the core register block
`timescale 1ns/1ps
module tb_cps_core_regs;
  logic clock = 0, rst_n = 0, reg_wr_en, ptr_add_en, ptr_use_en, loop_end_instr, call_instr, return_instr;
  logic chain_wr_en, stat_wr_en, mode_set_en, mode_clr_en, alu_flags_en, alu_carry, alu_overflow;
  logic test_wr_en, mem_rd_en, mem_tag_bit, chk, t;
  logic [2:0] reg_wr_sel, reg_rd_sel, ptr_add_sel, ptr_use_sel, mode_sel;
  logic [15:0] reg_wr_data, ptr_add_value, dst_value, v;
  logic [4:0] chain_wr_data;
  logic [16:0] stat_wr_data, st;
  logic [1:0] dst_kind, test_wr_data;
  logic [80:0] e;
  wire [15:0] index_value, page_base_value, stack_pointer_value;
  wire sign_extend_mode, unsigned_multiply_mode, saturation_mode, fraction_shift_mode, interrupt_enable_bit;
  wire [4:0] mode_bits = {interrupt_enable_bit, fraction_shift_mode, saturation_mode, unsigned_multiply_mode,
    sign_extend_mode};
  wire [15:0] reg_rd_data;
  wire [16:0] condition_mode_word;
  wire [4:0] chain_length_reg;
  wire [5:0] string_words;
  wire loop_taken, chain_illegal;
  logic [15:0] r [8];
  logic [80:0] q [$];
  int mismatches = 0, num_checks = 0, k, n, nv [4] = '{0, 1, 5, 32767};
  cps_core_regs DUT (.*);
  task check(input logic [16:0] seen, input logic [16:0] want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task step(input logic c);
    chk = c;
    if (c) q.push_back({r[reg_rd_sel], r[5], r[6], r[7], st});
    @(posedge clock);
    @(negedge clock);
    {reg_wr_en, ptr_add_en, ptr_use_en, loop_end_instr, call_instr, return_instr, chain_wr_en, stat_wr_en} = '0;
    {mode_set_en, mode_clr_en, alu_flags_en, test_wr_en, mem_rd_en, chk, dst_kind} = '0;
  endtask
  task report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #10 clock = ~clock;
  initial begin
    #1500000 mismatches++;
    report_and_stop();
  end
  // ========================================
  // result watcher
  always @(posedge clock) begin
    if (chk === 1'b1) begin
      #1 e = q.pop_front();
      check({1'b0, reg_rd_data}, {1'b0, e[80:65]});
      check({1'b0, index_value}, {1'b0, e[64:49]});
      check({1'b0, page_base_value}, {1'b0, e[48:33]});
      check({1'b0, stack_pointer_value}, {1'b0, e[32:17]});
      check({12'h000, mode_bits}, {12'h000, e[4:0]});
      check(condition_mode_word, e[16:0]);
    end
  end
  initial begin
    k = $urandom(32'h9B6D);
    {reg_wr_sel, reg_rd_sel, ptr_add_sel, ptr_use_sel, mode_sel, reg_wr_data, ptr_add_value, dst_value} = '0;
    {chain_wr_data, stat_wr_data, test_wr_data, alu_carry, alu_overflow, mem_tag_bit} = '0;
    step(0);
    for (k = 0; k < 8; k++) r[k] = 16'h0000;
    st = 17'h00000;
    repeat (7) @(posedge clock);
    @(negedge clock) rst_n = 1;
    for (k = 0; k < 8; k++) begin
      reg_wr_en = 1; reg_wr_sel = 3'(k); reg_rd_sel = 3'(k); reg_wr_data = 16'($urandom); r[k] = reg_wr_data;
      step(1);
    end
    for (k = 0; k < 3; k++) begin
      call_instr = k < 2; return_instr = k == 2; r[7] = (k < 2) ? r[7] + 16'h0002 : r[7] - 16'h0002;
      step(1);
    end
    for (n = 0; n < 4; n++) begin
      reg_wr_en = 1; reg_wr_sel = 3'h4; reg_rd_sel = 3'h4; reg_wr_data = 16'(nv[n]); r[4] = reg_wr_data;
      step(1);
      k = 0;
      do begin
        loop_end_instr = 1; #1 t = loop_taken; k += t; r[4] = r[4] - 16'h0001;
        step(k < 3);
      end while (t === 1'b1 && k < 40000);
      check(17'(k), 17'(nv[n] + 1));
    end
    for (k = 0; k < 4; k++) begin
      n = (k == 0) ? 0 : (k == 3) ? $urandom_range(31) : 29 + k;
      chain_wr_en = 1; chain_wr_data = n[4:0];
      step(0);
      step(0);
      check({11'h000, string_words}, 17'(n + 2));
      check({16'h0000, chain_illegal}, {16'h0000, n > 30});
    end
    stat_wr_en = 1; stat_wr_data = 17'($urandom); st = stat_wr_data & 17'h1FFDF;
    step(1);
    stat_wr_en = 1; stat_wr_data = 17'h00000; st = 17'h00000;
    step(1);
    for (k = 0; k < 11; k++) begin
      mode_sel = (k == 10) ? 3'h7 : 3'(k % 5); mode_set_en = k < 5 || k == 10; mode_clr_en = !mode_set_en;
      if (k < 10) st[k % 5] = k < 5;
      step(1);
    end
    reg_wr_en = 1; reg_wr_sel = 3'h1; reg_wr_data = 16'h0000; r[1] = 16'h0000; reg_rd_sel = 3'h0;
    step(1);
    for (k = 0; k < 16; k++) begin
      v = (k % 8 == 1) ? 16'h0000 : 16'($urandom); dst_value = v; dst_kind = 2'(k); alu_flags_en = 1;
      {alu_carry, alu_overflow} = 2'($urandom); ptr_add_en = dst_kind == 2'h2; ptr_add_value = v;
      ptr_use_en = dst_kind == 2'h0; ptr_use_sel = {2'b00, k[2]}; test_wr_en = 1; mem_rd_en = 1;
      test_wr_data = 2'($urandom); mem_tag_bit = 1'($urandom);
      case (dst_kind)
        2'h0: st[9] = r[ptr_use_sel] == 16'h0000;
        2'h1: st[13:10] = {alu_carry, v == 16'h0000, v[15], alu_overflow};
        2'h2: {st[9], st[8], r[0]} = {v == 16'h0000, {1'b0, r[0]} + {1'b0, v}};
        default: st[7:6] = {v[15], v == 16'h0000};
      endcase
      st[16:14] = {mem_tag_bit, test_wr_data};
      step(1);
    end
    report_and_stop();
  end
endmodule
